// ==== jtag_host.sv ====
// Host model that drives the test port pins
`timescale 1ns/1ps
module jtag_host (
	input wire logic i_clk,
	input wire logic i_tdo,
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi
);
	initial begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b0;
	end
	////////////////////////////////////////////////////////////
	// TCK low 5 clk, high 3 clk; TDO taken just before the rise
	task automatic bit_t(input logic tms, input logic tdi, output logic tdo);
		@(negedge i_clk);
		o_tms = tms;
		o_tdi = tdi;
		o_tck = 1'b0;
		repeat (5) @(negedge i_clk);
		tdo = i_tdo;
		o_tck = 1'b1;
		repeat (2) @(negedge i_clk);
	endtask
	// Data line toggles when it carries nothing
	task automatic walk(input logic [7:0] tms, input int n);
		logic d;
		for (int i = 0; i < n; i++) bit_t(tms[i], ~o_tdi, d);
	endtask
	task automatic shift(input logic [15:0] v, input int n, output logic [15:0] q);
		q = '0;
		for (int i = 0; i < n; i++) bit_t(i == n - 1, v[i], q[i]);
		walk(8'h01, 2);
		// Let the pulses of the last rise land before the caller looks
		repeat (4) @(negedge i_clk);
	endtask
	task automatic ir(input logic [3:0] c);
		logic [15:0] q;
		// Leading idle bit also leaves Test-Logic-Reset
		walk(8'h06, 5);
		shift({12'h0, c}, 4, q);
	endtask
	task automatic dr(input logic [15:0] v, input int n, output logic [15:0] q);
		walk(8'h01, 3);
		shift(v, n, q);
	endtask
endmodule

// ==== prog_port.sv ====
// TAP-driven programming registers: reset hold, unlock key, command and page data
`timescale 1ns/1ps
// What this block does
// R1 - Code 0x5 selects 15-bit command register
// R2 - Capture-DR loads previous command result
// R3 - Shift-DR shifts result out, command in
// R4 - Update-DR applies command to flash inputs
// R5 - Entering Run-Test/Idle gives one execute pulse
// R6 - Code 0x6 selects 8-bit load byte
// R7 - Update-DR copies byte, writes within 11 TCK
// R8 - Load writes alternate low, high, low first
// R9 - Counter steps before low writes except first
// R10 - Code 0x7 selects 8-bit read byte
// R11 - Capture alternates low/high, low first
// R12 - Counter steps after every high byte read
// R13 - Reset bit one holds chip in reset
// R14 - Reset time-out follows release of bit
// R15 - Reset bit acts unlatched, immediately
// R16 - Host resets chip before unlocking
// R17 - Enable only when key equals signature
// R18 - Power-on reset clears the key
// R19 - Host clears key when leaving programming
// R20 - All shift registers move LSB first
// R21 - Instruction register is four bits
// R22 - Code 0xC selects reset bit only
// R23 - Update-DR under unlock checks signature
// R24 - Locked: no commands, no page writes
module prog_port
	import prog_port_pkg::*;
#(
	parameter int TIMEOUT_W = 16
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic i_tdi,
	input wire logic [CMD_W-1:0] i_cmd_result,
	input wire logic [2*BYTE_W-1:0] i_flash_word,
	input wire logic [TIMEOUT_W-1:0] i_timeout_cycles,
	output logic o_tdo,
	output logic o_tdo_oe,
	output logic o_chip_reset,
	output logic o_prog_enabled,
	output logic [CMD_W-1:0] o_flash_cmd,
	output logic o_cmd_exec,
	output logic o_pbuf_wr,
	output logic o_pbuf_high,
	output logic [BYTE_W-1:0] o_pbuf_data,
	output logic o_pc_inc
);

	function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
		unique case (s)
			TLR: tap_next = tms ? TLR : RTI;
			RTI: tap_next = tms ? SEL_DR : RTI;
			SEL_DR: tap_next = tms ? SEL_IR : CAP_DR;
			CAP_DR: tap_next = tms ? EX1_DR : SH_DR;
			SH_DR: tap_next = tms ? EX1_DR : SH_DR;
			EX1_DR: tap_next = tms ? UPD_DR : PAU_DR;
			PAU_DR: tap_next = tms ? EX2_DR : PAU_DR;
			EX2_DR: tap_next = tms ? UPD_DR : SH_DR;
			UPD_DR: tap_next = tms ? SEL_DR : RTI;
			SEL_IR: tap_next = tms ? TLR : CAP_IR;
			CAP_IR: tap_next = tms ? EX1_IR : SH_IR;
			SH_IR: tap_next = tms ? EX1_IR : SH_IR;
			EX1_IR: tap_next = tms ? UPD_IR : PAU_IR;
			PAU_IR: tap_next = tms ? EX2_IR : PAU_IR;
			EX2_IR: tap_next = tms ? UPD_IR : SH_IR;
			UPD_IR: tap_next = tms ? SEL_DR : RTI;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: TCK is slow enough to be sampled and edge-detected
	logic tck_s1_r, tck_s2_r, tck_d_r, tms_s1_r, tms_s2_r, tdi_s1_r, tdi_s2_r;
	logic tck_rise, tck_fall;

	always_ff @(posedge i_clk) begin
		tck_s1_r <= i_tck;
		tck_s2_r <= tck_s1_r;
		tms_s1_r <= i_tms;
		tms_s2_r <= tms_s1_r;
		tdi_s1_r <= i_tdi;
		tdi_s2_r <= tdi_s1_r;
		tck_d_r <= i_rst_n ? tck_s2_r : 1'b0;
	end

	assign tck_rise = tck_s2_r & ~tck_d_r;
	assign tck_fall = ~tck_s2_r & tck_d_r;

	////////////////////////////////////////////////////////////////////////////
	tap_state_t tap_r, tap_nxt;
	logic [IR_W-1:0] ir_r, ir_nxt, ir_sh_r, ir_sh_nxt;
	logic rst_bit_r, rst_bit_nxt, byp_r, byp_nxt;
	logic [KEY_W-1:0] key_r, key_nxt;
	logic [CMD_W-1:0] cmd_sh_r, cmd_sh_nxt, flash_cmd_r, flash_cmd_nxt;
	logic en_r, en_nxt, hi_r, hi_nxt, first_r, first_nxt;
	logic tdo_r, tdo_nxt, tdo_oe_r, tdo_oe_nxt;
	logic exec_r, exec_nxt, pend_r, pend_nxt, wr_r, wr_nxt;
	logic phigh_r, phigh_nxt, pcinc_r, pcinc_nxt;
	logic [BYTE_W-1:0] tmp_r, tmp_nxt;
	logic [TIMEOUT_W-1:0] tmo_r, tmo_nxt;
	logic upd_dr, cap_dr, sh_dr;

	assign cap_dr = tck_rise && (tap_r == CAP_DR);
	assign sh_dr = tck_rise && (tap_r == SH_DR);
	assign upd_dr = tck_rise && (tap_r == UPD_DR);

	always_comb begin
		tap_nxt = tap_r;
		ir_nxt = ir_r;
		ir_sh_nxt = ir_sh_r;
		rst_bit_nxt = rst_bit_r;
		byp_nxt = byp_r;
		key_nxt = key_r;
		cmd_sh_nxt = cmd_sh_r;
		flash_cmd_nxt = flash_cmd_r;
		en_nxt = en_r;
		hi_nxt = hi_r;
		first_nxt = first_r;
		tdo_nxt = tdo_r;
		tdo_oe_nxt = tdo_oe_r;
		exec_nxt = 1'b0;
		pend_nxt = 1'b0;
		wr_nxt = pend_r;
		phigh_nxt = phigh_r;
		pcinc_nxt = 1'b0;
		tmp_nxt = tmp_r;
		tmo_nxt = tmo_r;
		// Time-out reloads while held, counts down after release
		if (rst_bit_r) begin
			tmo_nxt = i_timeout_cycles; // see R14
		end else if (tmo_r != '0) begin
			tmo_nxt = tmo_r - 1'b1; // see R14
		end
		if (tck_rise) begin
			tap_nxt = tap_next(tap_r, tms_s2_r);
			unique case (tap_r)
				TLR: ir_nxt = BYPASS_INSTR;
				CAP_IR: ir_sh_nxt = IR_CAPTURE_VAL;
				SH_IR: ir_sh_nxt = {tdi_s2_r, ir_sh_r[IR_W-1:1]}; // see R21, R20
				UPD_IR: begin
					ir_nxt = ir_sh_r; // see R21
					hi_nxt = 1'b0; // see R8, R11
					first_nxt = 1'b1; // see R9
				end
				CAP_DR: begin
					byp_nxt = 1'b0;
					if (ir_r == CMD_ENTRY_INSTR) begin
						cmd_sh_nxt = i_cmd_result; // see R2
					end else if (ir_r == PAGE_CAPTURE_INSTR) begin
						// see R11
						cmd_sh_nxt[BYTE_W-1:0] = hi_r ? i_flash_word[2*BYTE_W-1:BYTE_W]
							: i_flash_word[BYTE_W-1:0];
						hi_nxt = ~hi_r;
						pcinc_nxt = hi_r; // see R12
					end
				end
				SH_DR: begin
					unique case (ir_r)
						CMD_ENTRY_INSTR: cmd_sh_nxt = {tdi_s2_r, cmd_sh_r[CMD_W-1:1]}; // see R1, R3, R20
						PAGE_BUFFER_LOAD_INSTR, PAGE_CAPTURE_INSTR:
							cmd_sh_nxt[BYTE_W-1:0] = {tdi_s2_r, cmd_sh_r[BYTE_W-1:1]}; // see R6, R10, R20
						UNLOCK_INSTR: key_nxt = {tdi_s2_r, key_r[KEY_W-1:1]}; // see R20
						CHIP_HOLD_RESET_INSTR: rst_bit_nxt = tdi_s2_r; // see R22, R15
						default: byp_nxt = tdi_s2_r;
					endcase
				end
				UPD_DR: begin
					if (ir_r == UNLOCK_INSTR) begin
						en_nxt = (key_r == UNLOCK_SIGNATURE); // see R17, R23
					end else if (ir_r == CMD_ENTRY_INSTR && en_r) begin
						flash_cmd_nxt = cmd_sh_r; // see R4, R24
						exec_nxt = !tms_s2_r; // see R5
					end else if (ir_r == PAGE_BUFFER_LOAD_INSTR && en_r) begin
						tmp_nxt = cmd_sh_r[BYTE_W-1:0]; // see R7
						pend_nxt = 1'b1; // see R7
						phigh_nxt = hi_r; // see R8
						hi_nxt = ~hi_r; // see R8
						pcinc_nxt = !hi_r && !first_r; // see R9
						first_nxt = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// TDO changes on the falling edge so the host samples it stable
		if (tck_fall) begin
			tdo_oe_nxt = (tap_r == SH_DR) || (tap_r == SH_IR);
			if (tap_r == SH_IR) begin
				tdo_nxt = ir_sh_r[0];
			end else begin
				unique case (ir_r)
					CMD_ENTRY_INSTR, PAGE_BUFFER_LOAD_INSTR, PAGE_CAPTURE_INSTR:
						tdo_nxt = cmd_sh_r[0]; // see R20
					UNLOCK_INSTR: tdo_nxt = key_r[0];
					CHIP_HOLD_RESET_INSTR: tdo_nxt = rst_bit_r;
					default: tdo_nxt = byp_r;
				endcase
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			tap_r <= TLR;
			ir_r <= BYPASS_INSTR;
			ir_sh_r <= '0;
			rst_bit_r <= 1'b0;
			byp_r <= 1'b0;
			key_r <= KEY_RESET_VAL; // see R18
			cmd_sh_r <= '0;
			flash_cmd_r <= '0;
			en_r <= 1'b0;
			hi_r <= 1'b0;
			first_r <= 1'b1;
			tdo_r <= 1'b0;
			tdo_oe_r <= 1'b0;
			exec_r <= 1'b0;
			pend_r <= 1'b0;
			wr_r <= 1'b0;
			phigh_r <= 1'b0;
			pcinc_r <= 1'b0;
			tmp_r <= '0;
			tmo_r <= '0;
		end else begin
			tap_r <= tap_nxt;
			ir_r <= ir_nxt;
			ir_sh_r <= ir_sh_nxt;
			rst_bit_r <= rst_bit_nxt;
			byp_r <= byp_nxt;
			key_r <= key_nxt;
			cmd_sh_r <= cmd_sh_nxt;
			flash_cmd_r <= flash_cmd_nxt;
			en_r <= en_nxt;
			hi_r <= hi_nxt;
			first_r <= first_nxt;
			tdo_r <= tdo_nxt;
			tdo_oe_r <= tdo_oe_nxt;
			exec_r <= exec_nxt;
			pend_r <= pend_nxt;
			wr_r <= wr_nxt;
			phigh_r <= phigh_nxt;
			pcinc_r <= pcinc_nxt;
			tmp_r <= tmp_nxt;
			tmo_r <= tmo_nxt;
		end
	end

	// Reset bit drives the chip reset straight from the shift stage
	assign o_chip_reset = rst_bit_r || (tmo_r != '0); // see R13, R15
	assign o_prog_enabled = en_r;
	assign o_flash_cmd = flash_cmd_r;
	assign o_cmd_exec = exec_r;
	assign o_pbuf_wr = wr_r;
	assign o_pbuf_high = phigh_r;
	assign o_pbuf_data = tmp_r;
	assign o_pc_inc = pcinc_r;
	assign o_tdo = tdo_r;
	assign o_tdo_oe = tdo_oe_r;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	property p_locked_quiet;
		(o_cmd_exec || o_pbuf_wr) |-> $past(en_r, 2);
	endproperty
	a_locked_quiet: assert property (p_locked_quiet) else $error("action while locked"); // see R24

	property p_unlock_check;
		(upd_dr && ir_r == UNLOCK_INSTR) |=> (o_prog_enabled == ($past(key_r) == UNLOCK_SIGNATURE));
	endproperty
	a_unlock_check: assert property (p_unlock_check) else $error("bad unlock compare"); // see R17

	property p_hold_reset;
		(sh_dr && ir_r == CHIP_HOLD_RESET_INSTR && tdi_s2_r) |=> o_chip_reset;
	endproperty
	a_hold_reset: assert property (p_hold_reset) else $error("reset bit not obeyed"); // see R13, R15

	property p_timeout;
		($fell(rst_bit_r) && i_timeout_cycles > 1) |-> o_chip_reset ##1 o_chip_reset;
	endproperty
	a_timeout: assert property (p_timeout) else $error("time-out skipped"); // see R14

	property p_pbuf_write;
		(upd_dr && ir_r == PAGE_BUFFER_LOAD_INSTR && en_r) |->
			##2 (o_pbuf_wr && o_pbuf_data == $past(cmd_sh_r[BYTE_W-1:0], 2));
	endproperty
	a_pbuf_write: assert property (p_pbuf_write) else $error("page write late or wrong"); // see R7

	property p_cmd_apply;
		(upd_dr && ir_r == CMD_ENTRY_INSTR && en_r) |=> (o_flash_cmd == $past(cmd_sh_r));
	endproperty
	a_cmd_apply: assert property (p_cmd_apply) else $error("command not applied"); // see R4

	property p_exec_once;
		o_cmd_exec |=> !o_cmd_exec [*4];
	endproperty
	a_exec_once: assert property (p_exec_once) else $error("execute pulse repeated"); // see R5

	property p_read_step;
		(cap_dr && ir_r == PAGE_CAPTURE_INSTR) |=> (o_pc_inc == $past(hi_r));
	endproperty
	a_read_step: assert property (p_read_step) else $error("read counter step wrong"); // see R12

	property p_load_first;
		(upd_dr && ir_r == PAGE_BUFFER_LOAD_INSTR && en_r && first_r) |=>
			(!o_pc_inc && !o_pbuf_high);
	endproperty
	a_load_first: assert property (p_load_first) else $error("first load stepped"); // see R9, R8

	c_unlock: cover property (o_prog_enabled);
	c_exec: cover property (o_cmd_exec);
	c_high_write: cover property (o_pbuf_wr && o_pbuf_high);
	c_read_step: cover property (o_pc_inc && ir_r == PAGE_CAPTURE_INSTR);
endmodule

// ==== prog_port_pkg.sv ====
// Shared constants and types for the programming test-data registers
package prog_port_pkg;
	localparam int IR_W = 4;
	localparam int CMD_W = 15;
	localparam int KEY_W = 16;
	localparam int BYTE_W = 8;
	localparam logic [IR_W-1:0] CMD_ENTRY_INSTR = 4'h5;
	localparam logic [IR_W-1:0] PAGE_BUFFER_LOAD_INSTR = 4'h6;
	localparam logic [IR_W-1:0] PAGE_CAPTURE_INSTR = 4'h7;
	localparam logic [IR_W-1:0] UNLOCK_INSTR = 4'h4;
	localparam logic [IR_W-1:0] CHIP_HOLD_RESET_INSTR = 4'hC;
	localparam logic [IR_W-1:0] BYPASS_INSTR = 4'hF;
	localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 4'h1;
	localparam logic [KEY_W-1:0] UNLOCK_SIGNATURE = 16'hA370;
	localparam logic [KEY_W-1:0] KEY_RESET_VAL = 16'h0000;
	localparam int PBUF_WRITE_MAX_TCK = 11;

	typedef enum logic [3:0] {
		TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
		SH_DR = 4'h4, EX1_DR = 4'h5, PAU_DR = 4'h6, EX2_DR = 4'h7,
		UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'hA, SH_IR = 4'hB,
		EX1_IR = 4'hC, PAU_IR = 4'hD, EX2_IR = 4'hE, UPD_IR = 4'hF
	} tap_state_t;
endpackage

// ==== tb.sv ====
// Self-checking bench for the programming test-data registers
`timescale 1ns/1ps
module tb import prog_port_pkg::*; ();
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [CMD_W-1:0] i_cmd_result = '0;
	logic [2*BYTE_W-1:0] i_flash_word = '0;
	logic tck, tms, tdi, tdo, tdo_oe, chip_rst, prog_en, exec, wr, hi, pc_inc;
	logic [CMD_W-1:0] cmd;
	logic [BYTE_W-1:0] pdata;
	logic [17:0] exp_q[$];
	logic [15:0] q;
	logic [15:0] v;
	int num_errors = 0;
	int check_count = 0;
	always #12.5 i_clk = ~i_clk;
	prog_port uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
		.i_cmd_result(i_cmd_result), .i_flash_word(i_flash_word),
		.i_timeout_cycles(16'h0030), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
		.o_chip_reset(chip_rst), .o_prog_enabled(prog_en), .o_flash_cmd(cmd),
		.o_cmd_exec(exec), .o_pbuf_wr(wr), .o_pbuf_high(hi), .o_pbuf_data(pdata),
		.o_pc_inc(pc_inc));
	jtag_host host (.i_clk(i_clk), .i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [17:0] got, input logic [17:0] want);
		check_count++;
		if (got !== want) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, got, want);
		end
	endtask
	// Unexpected pulse meets an unknown note and fails
	task automatic take(input logic [17:0] got);
		logic [17:0] w;
		w = 'x;
		if (exp_q.size() > 0) w = exp_q.pop_front();
		chk(got, w);
	endtask
	always @(negedge i_clk) begin
		if (exec) take({3'h2, cmd});
		if (pc_inc) take(18'h30000);
		if (wr) take({2'h2, 7'h0, hi, pdata});
	end
	task automatic done_test(input string s);
		chk(18'(exp_q.size()), 18'h0);
		chk(18'(tdo_oe), 18'h0);
		$display("%s done", s);
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hF86AF52F));
		repeat (16) @(negedge i_clk);
		i_rst_n = 1'b1;
		repeat (4) @(negedge i_clk);
		chk(18'(prog_en), 18'h0);
		host.ir(CMD_ENTRY_INSTR);
		host.dr(16'h1234, CMD_W, q);
		chk(18'(cmd), 18'h0);
		done_test("locked");
		host.ir(CHIP_HOLD_RESET_INSTR);
		host.dr(16'h0001, 1, q);
		chk(18'(chip_rst), 18'h1);
		host.ir(UNLOCK_INSTR);
		host.dr(UNLOCK_SIGNATURE ^ 16'h8000, KEY_W, q);
		chk(18'(prog_en), 18'h0);
		host.dr(UNLOCK_SIGNATURE, KEY_W, q);
		chk(18'(prog_en), 18'h1);
		host.ir(CMD_ENTRY_INSTR);
		for (int i = 0; i < 3; i++) begin
			v = 16'($urandom());
			i_cmd_result = 15'($urandom());
			exp_q.push_back({3'h2, v[14:0]});
			host.dr(v, CMD_W, q);
			chk(18'(q), 18'(i_cmd_result));
			chk(18'(cmd), 18'(v[14:0]));
		end
		done_test("command");
		host.ir(PAGE_BUFFER_LOAD_INSTR);
		for (int i = 0; i < 5; i++) begin
			v = 16'($urandom());
			if (i > 1 && i[0] == 1'b0) exp_q.push_back(18'h30000);
			exp_q.push_back({2'h2, 7'h0, i[0], v[7:0]});
			host.dr(v, BYTE_W, q);
		end
		done_test("load");
		host.ir(PAGE_CAPTURE_INSTR);
		for (int i = 0; i < 4; i++) begin
			if (i[0] == 1'b0) i_flash_word = 16'($urandom());
			if (i[0]) exp_q.push_back(18'h30000);
			host.dr(16'h0000, BYTE_W, q);
			chk(18'(q), 18'(i[0] ? i_flash_word[15:8] : i_flash_word[7:0]));
		end
		done_test("read");
		host.ir(UNLOCK_INSTR);
		host.dr(KEY_RESET_VAL, KEY_W, q);
		chk(18'(prog_en), 18'h0);
		host.ir(PAGE_BUFFER_LOAD_INSTR);
		host.dr(16'h00A5, BYTE_W, q);
		done_test("relock");
		host.ir(CHIP_HOLD_RESET_INSTR);
		host.dr(16'h0000, 1, q);
		chk(18'(chip_rst), 18'h1);
		repeat (40) @(negedge i_clk);
		chk(18'(chip_rst), 18'h0);
		done_test("release");
		test_done();
	end
	// About six times the expected run
	initial begin
		repeat (20000) @(posedge i_clk);
		num_errors++;
		test_done();
	end
endmodule
